/* shared/commit_ctrl_params.svh */
// Constants for the register commit controller: offsets, field positions, counts.
// Assumes it is included by bare name from design and bench files.
`ifndef COMMIT_CTRL_PARAMS_SVH
`define COMMIT_CTRL_PARAMS_SVH

`define OFS_UPDATE_BLOCK     8'hFD
`define OFS_UPDATE_SYNC      8'hFE
`define OFS_MAIN_MODE        8'hFF
`define OFS_FACTORY_TEST     8'hFC
`define OFS_PORT_DIR         8'h10
`define OFS_PORT_OE          8'h11
`define OFS_ALU_ROUTE        8'h12
`define BIT_UPDATE_BLOCK     0
`define BIT_SYNC_COMMIT      0
`define BIT_PENDING          1
`define BIT_SOFT_RESET       0
`define BIT_FIELD_LATCH      1
`define RESET_VALUE          8'h00
`define SOFT_RESET_CYCLES    3
`define ALU_EXTRA_LATENCY    3

`endif

/* shared/commit_ctrl_pkg.sv */
// Types for the register commit controller.
// Assumes commit_ctrl_params.svh supplies the numeric constants.
`default_nettype none
package commit_ctrl_pkg;

  // Host strobe group, the three strobes active low, synchronous to the pixel clock
  typedef struct packed {
    logic       chip_select_n;
    logic       write_n;
    logic       read_n;
    logic [7:0] index;
    logic [7:0] data;
  } host_req_t;

  // Soft reset sequencer states, Gray coded
  typedef enum logic [1:0] {
    SR_IDLE  = 2'b00,
    SR_HOLD1 = 2'b01,
    SR_HOLD2 = 2'b11,
    SR_HOLD3 = 2'b10
  } soft_reset_state_t;

endpackage
`default_nettype wire

/* verilog/dual_stage_reg.sv */
// One register built of a first-stage latch and a second-stage active copy.
// Assumes write and commit strobes are one pixel clock wide.
`timescale 1ns/100ps
`default_nettype none
module dual_stage_reg #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             resetn_i,
  input  wire logic             clear_i,
  // Stage controls
  input  wire logic             write_i,
  input  wire logic [WIDTH-1:0] data_i,
  input  wire logic             commit_i,
  // Contents
  output logic      [WIDTH-1:0] first_o,
  output logic      [WIDTH-1:0] active_o
);

  logic [WIDTH-1:0] first_q;
  logic [WIDTH-1:0] active_q;

  // First stage takes the host data on a write
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      first_q <= '0;
    end else if (clear_i) begin
      first_q <= '0;
    end else if (write_i) begin
      first_q <= data_i;
    end
  end

  // Second stage opens its gate on commit; a same-cycle write passes straight through
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      active_q <= '0;
    end else if (clear_i) begin
      active_q <= '0;
    end else if (commit_i) begin
      active_q <= write_i ? data_i : first_q;
    end
  end

  assign first_o  = first_q;
  assign active_o = active_q;

endmodule
`default_nettype wire

/* verilog/sync_register_commit_control.sv */
// Mode control and register commit logic of an image stream switcher.
// Assumes host strobes and sync inputs are synchronous to the pixel clock.
`timescale 1ns/100ps
`default_nettype none
`include "commit_ctrl_params.svh"
module sync_register_commit_control #(
  parameter int NUM_PORTS = 8,
  parameter int DATA_W    = 8
) (
  // Clock and reset
  input  wire logic                     clk_sys_i,
  input  wire logic                     resetn_i,
  // Host register port
  input  wire commit_ctrl_pkg::host_req_t host_i,
  output logic [7:0]                    host_data_bus_o,
  output logic                          host_data_bus_oe_n_o,
  // Sync inputs
  input  wire logic                     vertical_sync_n_i,
  input  wire logic                     vsync_qualifier_n_i,
  input  wire logic                     horizontal_sync_n_i,
  input  wire logic                     field_identity_in_i,
  // Stream data for arithmetic routing
  input  wire logic [DATA_W-1:0]        alu_data_i,
  output logic      [DATA_W-1:0]        alu_data_o,
  // Status and port control
  output logic                          frame_sync_pulse_o,
  output logic                          field_identity_o,
  output logic                          pending_write_o,
  output logic                          test_mode_o,
  output logic      [NUM_PORTS-1:0]     port_direction_out_o,
  output logic      [NUM_PORTS-1:0]     port_output_enable_n_o
);

  localparam int NREG = 4;
  // Index of each dual-stage register
  localparam int R_BLOCK = 0;
  localparam int R_DIR   = 1;
  localparam int R_OE    = 2;
  localparam int R_ROUTE = 3;

  logic                         wr_stb;
  logic                         rd_stb;
  logic                         update_block_q;
  logic                         sync_commit_q;
  logic                         field_latch_select_q;
  logic                         pending_q;
  logic                         test_q;
  logic                         vs_qual_q;
  logic                         vs_pulse_q;
  logic                         vs_prev_q;
  logic                         field_q;
  logic                         commit;
  logic                         clear_all;
  logic [7:0]                   rd_data_d;
  logic [7:0]                   rd_data_q;
  logic                         rd_en_q;
  logic [NREG-1:0]              reg_wr;
  logic [7:0]                   first_w  [NREG];
  logic [7:0]                   active_w [NREG];
  logic [DATA_W-1:0]            alu_pipe_q [`ALU_EXTRA_LATENCY];
  commit_ctrl_pkg::soft_reset_state_t sr_state_q;

  assign wr_stb = !host_i.chip_select_n && !host_i.write_n;
  // Write wins if the host breaks the strobe exclusivity it promised
  assign rd_stb = !host_i.chip_select_n && !host_i.read_n && host_i.write_n;

  // Soft reset sequencer: clears the mode flags, pending flag and dual-stage registers for three cycles after the write
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sr_state_q <= commit_ctrl_pkg::SR_IDLE;
    end else begin
      case (sr_state_q)
        commit_ctrl_pkg::SR_IDLE: begin
          if (wr_stb && host_i.index == `OFS_MAIN_MODE && host_i.data[`BIT_SOFT_RESET]) begin
            sr_state_q <= commit_ctrl_pkg::SR_HOLD1;
          end
        end
        commit_ctrl_pkg::SR_HOLD1: sr_state_q <= commit_ctrl_pkg::SR_HOLD2;
        commit_ctrl_pkg::SR_HOLD2: sr_state_q <= commit_ctrl_pkg::SR_HOLD3;
        commit_ctrl_pkg::SR_HOLD3: sr_state_q <= commit_ctrl_pkg::SR_IDLE;
        default:                   sr_state_q <= commit_ctrl_pkg::SR_IDLE;
      endcase
    end
  end

  assign clear_all = (sr_state_q != commit_ctrl_pkg::SR_IDLE);

  // Qualifier sampled the cycle before vsync low; one pulse per qualified edge
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vs_qual_q  <= 1'b0;
      vs_prev_q  <= 1'b1;
      vs_pulse_q <= 1'b0;
    end else begin
      vs_qual_q  <= !vsync_qualifier_n_i;
      vs_prev_q  <= vertical_sync_n_i;
      vs_pulse_q <= vs_prev_q && !vertical_sync_n_i && vs_qual_q;
    end
  end

  // Commit gate: direct in async mode, on the vsync pulse in sync mode
  always_comb begin
    if (update_block_q) begin
      commit = 1'b0;
    end else if (sync_commit_q) begin
      commit = vs_pulse_q;
    end else begin
      commit = 1'b1;
    end
  end

  // Mode flags act on the written value at once, except that a sync-commit write is ignored while update block is set
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      update_block_q       <= 1'b0;
      sync_commit_q        <= 1'b0;
      field_latch_select_q <= 1'b0;
      test_q               <= 1'b0;
    end else if (clear_all) begin
      update_block_q       <= 1'b0;
      sync_commit_q        <= 1'b0;
      field_latch_select_q <= 1'b0;
      test_q               <= 1'b0;
    end else if (wr_stb) begin
      case (host_i.index)
        `OFS_UPDATE_BLOCK: update_block_q <= host_i.data[`BIT_UPDATE_BLOCK];
        `OFS_UPDATE_SYNC: begin
          if (!update_block_q) begin
            sync_commit_q <= host_i.data[`BIT_SYNC_COMMIT];
          end
        end
        `OFS_MAIN_MODE:    field_latch_select_q <= host_i.data[`BIT_FIELD_LATCH];
        `OFS_FACTORY_TEST: test_q <= host_i.data[0];
        default: begin
        end
      endcase
    end
  end

  // Pending flag: set on any write, clear on transfer, clear has priority
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pending_q <= 1'b0;
    end else if (clear_all || commit) begin
      pending_q <= 1'b0;
    end else if (wr_stb) begin
      pending_q <= 1'b1;
    end
  end

  // Write decode for the dual-stage registers
  always_comb begin
    reg_wr = '0;
    if (wr_stb) begin
      case (host_i.index)
        `OFS_PORT_DIR:  reg_wr[R_DIR]   = 1'b1;
        `OFS_PORT_OE:   reg_wr[R_OE]    = 1'b1;
        `OFS_ALU_ROUTE: reg_wr[R_ROUTE] = 1'b1;
        default:        reg_wr          = '0;
      endcase
    end
  end
  assign first_w[R_BLOCK]  = 8'h00;
  assign active_w[R_BLOCK] = 8'h00;

  // One dual-stage register per steered function
  for (genvar g = 1; g < NREG; g++) begin : g_reg
    dual_stage_reg #(
      .WIDTH(8)
    ) u_reg (
      .clk_sys_i(clk_sys_i),
      .resetn_i (resetn_i),
      .clear_i  (clear_all),
      .write_i  (reg_wr[g]),
      .data_i   (host_i.data),
      .commit_i (commit),
      .first_o  (first_w[g]),
      .active_o (active_w[g])
    );
  end

  // Field identity: live, or caught on the edge after vsync falls
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      field_q <= 1'b0;
    end else if (vs_prev_q && !vertical_sync_n_i) begin
      field_q <= field_identity_in_i;
    end
  end
  // Live sampling relies on the source holding the level steady
  assign field_identity_o = field_latch_select_q ? field_q : field_identity_in_i;

  // Read mux returns first-stage contents
  always_comb begin
    rd_data_d = `RESET_VALUE;
    case (host_i.index)
      `OFS_UPDATE_BLOCK: rd_data_d = {7'h00, update_block_q};
      `OFS_UPDATE_SYNC:  rd_data_d = {6'h00, pending_q, sync_commit_q};
      `OFS_MAIN_MODE:    rd_data_d = {6'h00, field_latch_select_q, 1'b0};
      `OFS_FACTORY_TEST: rd_data_d = {7'h00, test_q};
      `OFS_PORT_DIR:     rd_data_d = first_w[R_DIR];
      `OFS_PORT_OE:      rd_data_d = first_w[R_OE];
      `OFS_ALU_ROUTE:    rd_data_d = first_w[R_ROUTE];
      default:           rd_data_d = `RESET_VALUE;
    endcase
  end

  // Registered read data and bus enable
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_data_q <= 8'h00;
      rd_en_q   <= 1'b0;
    end else begin
      rd_data_q <= rd_data_d;
      rd_en_q   <= rd_stb;
    end
  end

  // Arithmetic path delay; kept even when bypassed to keep the pipeline simple
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < `ALU_EXTRA_LATENCY; i++) begin
        alu_pipe_q[i] <= '0;
      end
    end else begin
      alu_pipe_q[0] <= alu_data_i;
      for (int i = 1; i < `ALU_EXTRA_LATENCY; i++) begin
        alu_pipe_q[i] <= alu_pipe_q[i-1];
      end
    end
  end

  // Port control comes from flip-flops so direction never glitches mid-cycle
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      port_direction_out_o   <= '0;
      port_output_enable_n_o <= '1;
      alu_data_o             <= '0;
    end else begin
      port_direction_out_o   <= active_w[R_DIR][NUM_PORTS-1:0];
      // A set enable bit drives the port low-active; zero leaves it in Hi-Z
      port_output_enable_n_o <= ~active_w[R_OE][NUM_PORTS-1:0];
      alu_data_o             <= active_w[R_ROUTE][0] ? alu_pipe_q[`ALU_EXTRA_LATENCY-1]
                                                    : alu_data_i;
    end
  end

  assign host_data_bus_o      = rd_data_q;
  assign host_data_bus_oe_n_o = !rd_en_q;
  assign frame_sync_pulse_o   = vs_pulse_q;
  assign pending_write_o      = pending_q;
  // Test mode only flags itself; software must not set it
  assign test_mode_o          = test_q;

endmodule
`default_nettype wire

/* testbench/commit_ctrl_chk.sv */
// Concurrent checks on the register commit controller ports.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/100ps
`default_nettype none
`include "commit_ctrl_params.svh"
module commit_ctrl_chk #(
  parameter int NUM_PORTS = 8
) (
  // Clock and reset
  input wire logic                       clk_sys_i,
  input wire logic                       resetn_i,
  // Host and sync inputs
  input wire commit_ctrl_pkg::host_req_t host_i,
  input wire logic                       vertical_sync_n_i,
  input wire logic                       vsync_qualifier_n_i,
  // Watched outputs
  input wire logic                       host_data_bus_oe_n_o,
  input wire logic                       frame_sync_pulse_o,
  input wire logic                       pending_write_o,
  input wire logic [NUM_PORTS-1:0]       port_direction_out_o,
  input wire logic [NUM_PORTS-1:0]       port_output_enable_n_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  // Decoded strobes; a read only counts with the write strobe high
  wire logic rd = !host_i.chip_select_n && !host_i.read_n && host_i.write_n;
  wire logic wr = !host_i.chip_select_n && !host_i.write_n;
  // Qualified vsync fall and soft reset write
  sequence vs_fall_s;
    (vertical_sync_n_i && !vsync_qualifier_n_i) ##1 !vertical_sync_n_i;
  endsequence
  sequence soft_rst_s;
    wr && host_i.index == `OFS_MAIN_MODE && host_i.data[`BIT_SOFT_RESET];
  endsequence
  read_answer_a: assert property (rd |=> !host_data_bus_oe_n_o)
    else $error("read not answered");
  read_idle_a: assert property (!rd |=> host_data_bus_oe_n_o)
    else $error("bus driven without read");
  pulse_prompt_a: assert property (vs_fall_s |-> ##[1:2] frame_sync_pulse_o)
    else $error("qualified vsync gave no pulse");
  pulse_single_a: assert property (frame_sync_pulse_o |=> !frame_sync_pulse_o)
    else $error("vsync pulse longer than one cycle");
  pulse_cause_a: assert property (frame_sync_pulse_o |->
    (!$past(vertical_sync_n_i) || !$past(vertical_sync_n_i, 2)))
    else $error("pulse without vsync low");
  pending_set_a: assert property ($rose(pending_write_o) |-> $past(wr))
    else $error("pending set without write");
  soft_clear_a: assert property (soft_rst_s |->
    ##[1:5] (port_direction_out_o == '0 && !pending_write_o))
    else $error("soft reset did not clear");
  reset_values_a: assert property ($rose(resetn_i) |-> host_data_bus_oe_n_o
    && &port_output_enable_n_o && !pending_write_o)
    else $error("wrong value after reset");
endmodule
bind sync_register_commit_control commit_ctrl_chk #(.NUM_PORTS(NUM_PORTS)) chk_u (
  .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .host_i(host_i),
  .vertical_sync_n_i(vertical_sync_n_i), .vsync_qualifier_n_i(vsync_qualifier_n_i),
  .host_data_bus_oe_n_o(host_data_bus_oe_n_o), .frame_sync_pulse_o(frame_sync_pulse_o),
  .pending_write_o(pending_write_o), .port_direction_out_o(port_direction_out_o),
  .port_output_enable_n_o(port_output_enable_n_o));
`default_nettype wire

/* testbench/host_cpu_model.sv */
// Host CPU model driving the register strobe group.
// Assumes callers enter its task just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module host_cpu_model (
  // Clock
  input  wire logic                     clk_sys_i,
  // Strobe group
  output var commit_ctrl_pkg::host_req_t host_o
);
  initial host_o = '{1'b1, 1'b1, 1'b1, 8'h00, 8'h00};
  // One access, then an idle cycle so no strobe is assigned twice at one time
  task automatic cyc(input logic w, input logic [7:0] a, input logic [7:0] d);
    host_o = '{1'b0, ~w, w, a, d};
    @(posedge clk_sys_i);
    #1;
    // Released lines show the inverse, so stale values cannot pass
    host_o = '{1'b1, 1'b1, 1'b1, ~a, ~d};
    @(posedge clk_sys_i);
    #1;
  endtask
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench for the register commit controller.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
`include "commit_ctrl_params.svh"
module tb_top;
  logic clk_sys_i = 0, resetn_i = 0, vs_n = 1, vq_n = 0, fld = 0, p;
  logic [7:0] alu_in = 8'h00, alu_out, rdata, dir, oe_n, d1, d2, d3;
  logic oe_bus_n, pulse, fld_o, pend, test_o;
  logic [7:0] exp_q[$], hist[$];
  commit_ctrl_pkg::host_req_t host;
  int num_errors = 0, num_checks = 0, seed = 32'h3d64e35a;
  host_cpu_model host_u (.clk_sys_i(clk_sys_i), .host_o(host));
  sync_register_commit_control dut_u (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .host_i(host),
    .host_data_bus_o(rdata), .host_data_bus_oe_n_o(oe_bus_n),
    .vertical_sync_n_i(vs_n), .vsync_qualifier_n_i(vq_n),
    .horizontal_sync_n_i(1'b1), .field_identity_in_i(fld),
    .alu_data_i(alu_in), .alu_data_o(alu_out), .frame_sync_pulse_o(pulse),
    .field_identity_o(fld_o), .pending_write_o(pend), .test_mode_o(test_o),
    .port_direction_out_o(dir), .port_output_enable_n_o(oe_n));
  initial forever #4 clk_sys_i = ~clk_sys_i;
  task chk(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    host_u.cyc(1'b1, a, d);
  endtask
  // Read expectation noted before the access; the monitor takes it
  task rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host_u.cyc(1'b0, a, 8'h00);
  endtask
  // Vsync high two cycles, then low four; field identity held throughout
  task frame();
    p = 0;
    step(2);
    vs_n = 0;
    repeat (4) begin
      step(1);
      p |= pulse;
    end
    vs_n = 1;
    step(2);
    chk(p, 1);
  endtask
  // Read data is settled by the falling edge after the answer
  always @(negedge clk_sys_i) begin
    if (oe_bus_n === 1'b0) begin
      if (exp_q.size() > 0) chk(rdata, exp_q.pop_front());
      else chk(rdata, 8'hXX);
    end
  end
  task summarize();
    if (num_errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Whole sequence is about 115 cycles; this cuts off a hang
  initial begin
    #20000;
    num_errors++;
    summarize();
  end
  initial begin
    step(20);
    resetn_i = 1;
    chk(oe_n, 8'hFF);
    chk(pend, 0);
    d1 = 8'($random(seed));
    d2 = 8'($random(seed));
    d3 = 8'($random(seed));
    wr(`OFS_PORT_DIR, d1);
    chk(dir, d1);
    // Async write sets and clears pending in one cycle; the clear must win
    chk(pend, 0);
    wr(`OFS_PORT_OE, d2);
    chk(oe_n, ~d2);
    rd(8'h55, 8'h00);
    wr(`OFS_UPDATE_SYNC, 8'h01);
    wr(`OFS_PORT_DIR, d2);
    chk(pend, 1);
    chk(dir, d1);
    rd(`OFS_PORT_DIR, d2);
    rd(`OFS_UPDATE_SYNC, 8'h03);
    frame();
    chk(dir, d2);
    chk(pend, 0);
    wr(`OFS_UPDATE_BLOCK, 8'h01);
    wr(`OFS_PORT_DIR, d3);
    wr(`OFS_UPDATE_SYNC, 8'h00);
    frame();
    chk(dir, d2);
    rd(`OFS_UPDATE_SYNC, 8'h03);
    wr(`OFS_UPDATE_BLOCK, 8'h00);
    frame();
    chk(dir, d3);
    chk(pend, 0);
    wr(`OFS_MAIN_MODE, 8'h01);
    step(3);
    chk(dir, 8'h00);
    rd(`OFS_UPDATE_SYNC, 8'h00);
    rd(`OFS_MAIN_MODE, 8'h00);
    chk(test_o, 0);
    for (int m = 0; m < 2; m++) begin
      wr(`OFS_ALU_ROUTE, m[7:0]);
      hist.delete();
      for (int i = 0; i < 10; i++) begin
        alu_in = 8'($random(seed));
        hist.push_back(alu_in);
        step(1);
        if (i >= 3) chk(alu_out, hist[i - 3 * m]);
      end
    end
    fld = 1;
    step(2);
    chk(fld_o, 1);
    wr(`OFS_MAIN_MODE, 8'h02);
    step(2);
    vs_n = 0;
    step(2);
    fld = 0;
    step(2);
    chk(fld_o, 1);
    vs_n = 1;
    step(4);
    summarize();
  end
endmodule
`default_nettype wire
